// ==== uft_baud_gen.sv ====
// Baud rate down-counter that emits one tick each time it reaches zero.
`timescale 1ns/100ps
module uft_baud_gen
  import uft_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] baudDivisor,
  input wire logic divisorLowWrite,
  output logic baudTick
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Reload on zero or on a write of the low divisor byte, else count down.
  always_comb
  begin
    if (cnt_q == '0 || divisorLowWrite)
    begin
      cnt_d = baudDivisor;
    end
    else
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Counter register.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q <= W'(RST_DIVISOR);
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // One tick on each zero of the counter.
  assign baudTick = (cnt_q == '0);

endmodule

// ==== uft_edge_sync.sv ====
// Two-stage synchroniser with rising and falling edge strobes.
`timescale 1ns/100ps
module uft_edge_sync
  import uft_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic meta_d;
  logic sync_d;
  logic prev_d;

  // The first stage feeds only the second; edges are taken after it.
  always_comb
  begin
    meta_d = asyncIn;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Synchroniser and edge history registers.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      prev_q <= 1'h0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // One-cycle strobes on each edge of the synchronised level.
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ==== uft_line_monitor.sv ====
// Remote serial receiver model that samples the transmit line.
`timescale 1ns/100ps
module uft_line_monitor
(
  input wire logic core_clk,
  input wire logic txdOut,
  input wire logic [7:0] bitClks,
  input wire logic [3:0] frameLen,
  output logic [12:0] rxBits,
  output logic rxDone,
  input wire logic xckOn,
  output logic xckPin
);
  logic [1:0] xckDiv = 2'h0;

  // Bit clock of a remote master for slave mode: one period is eight system clocks.
  // It stands still low whenever slave clocking is not selected.
  always @(negedge core_clk)
  begin
    xckDiv <= xckDiv + 2'h1;
    if (xckDiv == 2'h3)
    begin
      xckPin <= xckOn & ~xckPin;
    end
  end

  // Waits for a low level, then samples each bit in its middle.
  initial
  begin
    rxBits = 13'h0000;
    rxDone = 1'h0;
    forever
    begin
      @(negedge core_clk);
      rxDone = 1'h0;
      if (txdOut === 1'h0)
      begin
        repeat (bitClks / 2) @(negedge core_clk);
        for (int i = 0; i < frameLen; i++)
        begin
          rxBits[i] = txdOut;
          if (i < frameLen - 1) repeat (bitClks) @(negedge core_clk);
        end
        rxDone = 1'h1;
      end
    end
  end
endmodule

// ==== uft_pkg.sv ====
// Shared constants, types and encodings of the serial frame transmitter.
package uft_pkg;

  // Widths of the divisor, the character and the longest frame.
  localparam int DIV_W = 12;
  localparam int DATA_W = 9;
  localparam int FRAME_W = 13;
  localparam int LEN_W = 4;
  localparam int PRE_W = 4;

  // Terminal prescaler counts that divide the baud tick by 16 and by 8.
  localparam logic [PRE_W-1:0] PRE_TERM_NORMAL = 4'hf;
  localparam logic [PRE_W-1:0] PRE_TERM_DOUBLE = 4'h7;

  // Character size field codes.
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;

  // Data bit counts that the size codes select.
  localparam logic [LEN_W-1:0] NBITS_5 = 4'h5;
  localparam logic [LEN_W-1:0] NBITS_6 = 4'h6;
  localparam logic [LEN_W-1:0] NBITS_7 = 4'h7;
  localparam logic [LEN_W-1:0] NBITS_8 = 4'h8;
  localparam logic [LEN_W-1:0] NBITS_9 = 4'h9;

  // Parity mode field codes; the upper bit enables parity, the lower picks odd.
  localparam logic [1:0] PAR_OFF = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam int PAR_EN_BIT = 1;
  localparam int PAR_ODD_BIT = 0;

  // Reset values.
  localparam logic RST_LINE = 1'h1;
  localparam logic RST_BUF_EMPTY = 1'h1;
  localparam logic RST_TX_COMPLETE = 1'h0;
  localparam logic RST_FRAME_ERROR = 1'h0;
  localparam logic RST_CLK_OUT = 1'h0;
  localparam logic [DIV_W-1:0] RST_DIVISOR = 12'h000;

  // Frame format shared by transmitter and receiver.
  typedef struct packed {
    logic [2:0] charSizeSel;
    logic [1:0] parityModeSel;
    logic stopBitsSel;
  } uft_format_s;

  // A frame ready for shifting: bit 0 goes out first.
  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [LEN_W-1:0] len;
  } uft_frame_s;

  // Clock source of the transmitter.
  typedef enum logic [1:0] {
    CLK_ASYNC,
    CLK_ASYNC_2X,
    CLK_SYNC_MASTER,
    CLK_SYNC_SLAVE
  } uft_clk_mode_e;

  // Shifter state.
  typedef enum logic {
    TX_IDLE,
    TX_SHIFT
  } uft_tx_state_e;

endpackage

// ==== uft_transmitter.sv ====
// Serial frame formatter and transmitter with buffer, flags and clock modes.
//
// How it works
// RULE1: Frames of one start, five to nine data, optional parity, one or two stops.
// RULE2: Data bits follow the start bit, least significant first.
// RULE3: The parity bit sits after the last data bit, before the stops.
// RULE4: A finished frame is followed at once by the next, or by idle.
// RULE5: Start bit is always low, every stop bit always high.
// RULE6: The line stays high whenever no frame is in progress.
// RULE7: One shared frame format governs transmitter and receiver.
// RULE8: Software keeps the format steady while traffic runs.
// RULE9: Three-bit size field sets data bits; seven selects nine bits.
// RULE10: Two-bit parity field enables parity and picks even or odd.
// RULE11: One stop select bit picks one or two stop bits.
// RULE12: Receiver ignores the second stop; frame error only if first stop is zero.
// RULE13: Even parity is the xor of the data bits; odd is its inverse.
// RULE14: Transmit enable hands the transmit pin over to the serial output.
// RULE15: Synchronous mode shifts on the external clock pin.
// RULE16: A data write loads the buffer and so starts a transmission.
// RULE17: Buffer moves to the shifter when idle or right after the last stop.
// RULE18: Bit rate comes from divisor and double speed, or the external clock.
// RULE19: Unused upper data bits are ignored for narrow characters.
// RULE20: Software sets the ninth bit before writing the low byte.
// RULE21: The buffer empty flag tells software when it may write again.
// RULE22: Software clears the complete flag before each data write.
// RULE23: Software checks for idle traffic before changing rate or format.
// RULE24: Bit clock is the baud tick divided by 16, 8 or 2.
// RULE25: Baud counter reloads on zero or low divisor write, ticks on zero.
// RULE26: Sync data changes on the rising clock edge for polarity zero, else falling.
// RULE27: Complete flag sets when the frame has left and the buffer is empty.
// RULE28: Size codes 0 to 3 give five to eight bits; codes 4 to 6 are reserved.
`timescale 1ns/100ps
module uft_transmitter
  import uft_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic txEnableBit,
  input uft_format_s frameFormat,
  input wire logic syncMode,
  input wire logic extClockIsOutput,
  input wire logic doubleSpeedBit,
  input wire logic syncClockPolarity,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic baudDivisorLowWrite,
  input wire logic charDataRegWrite,
  input wire logic [7:0] charDataRegByte,
  input wire logic txNinthBit,
  input wire logic txCompleteClear,
  input wire logic rxFirstStopStrobe,
  input wire logic rxFirstStopBit,
  input wire logic extBitClockPinIn,
  output logic extBitClockPinOut,
  output logic extBitClockPinOe_n,
  output logic txdOut,
  output logic txdOverride,
  output uft_format_s sharedFormat,
  output logic txBufferEmptyFlag,
  output logic txCompleteFlag,
  output logic frameErrorFlag,
  output logic txBusy
);

  // Data bit count for a size code; reserved codes fall back to eight.
  function automatic logic [LEN_W-1:0] dataBitCount(input logic [2:0] sel);
    logic [LEN_W-1:0] n;
    n = NBITS_8;
    case (sel)
      CSZ_5: n = NBITS_5;
      CSZ_6: n = NBITS_6;
      CSZ_7: n = NBITS_7;
      CSZ_8: n = NBITS_8;
      CSZ_9: n = NBITS_9; // [RULE9]
      default: n = NBITS_8; // [RULE28]
    endcase
    return n;
  endfunction

  // Parity over the bits that belong to the character only.
  function automatic logic parityOf(input logic [DATA_W-1:0] d, input uft_format_s f);
    logic p;
    logic [LEN_W-1:0] n;
    p = 1'h0;
    n = dataBitCount(f.charSizeSel);
    for (int i = 0; i < DATA_W; i++)
    begin
      if (LEN_W'(i) < n)
      begin
        p = p ^ d[i];
      end
    end
    return p ^ f.parityModeSel[PAR_ODD_BIT]; // [RULE13]
  endfunction

  // Lay out one whole frame, first bit to go out at position zero.
  function automatic uft_frame_s buildFrame(input logic [DATA_W-1:0] d, input uft_format_s f);
    uft_frame_s fr;
    logic [LEN_W-1:0] n;
    logic parEn;
    // Positions beyond the last stop bit stay high and are never shifted out.
    fr.bits = '1;
    fr.len = '0;
    n = dataBitCount(f.charSizeSel);
    parEn = f.parityModeSel[PAR_EN_BIT]; // [RULE10]
    fr.bits[0] = 1'h0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (LEN_W'(i) < n)
      begin
        fr.bits[1+i] = d[i];
      end
    end
    if (parEn)
    begin
      fr.bits[n+LEN_W'(1)] = parityOf(d, f);
    end
    fr.len = LEN_W'(1) + n + {3'h0, parEn} + (f.stopBitsSel ? LEN_W'(2) : LEN_W'(1)); // [RULE11]
    return fr;
  endfunction

  logic baudTick;
  logic xckRise;
  logic xckFall;
  uft_clk_mode_e clkMode;
  logic bitTick;
  logic loadShifter;
  logic frameDone;
  uft_frame_s nextFrame;

  uft_format_s format_q;
  uft_format_s format_d;
  logic [PRE_W-1:0] preCnt_q;
  logic [PRE_W-1:0] preCnt_d;
  logic xckOut_q;
  logic xckOut_d;
  logic [DATA_W-1:0] bufData_q;
  logic [DATA_W-1:0] bufData_d;
  logic bufFull_q;
  logic bufFull_d;
  uft_tx_state_e state_q;
  uft_tx_state_e state_d;
  logic [FRAME_W-1:0] shift_q;
  logic [FRAME_W-1:0] shift_d;
  logic [LEN_W-1:0] bitsLeft_q;
  logic [LEN_W-1:0] bitsLeft_d;
  logic txd_q;
  logic txd_d;
  logic override_q;
  logic override_d;
  logic txc_q;
  logic txc_d;
  logic fe_q;
  logic fe_d;

  // Baud rate generator on the system clock.
  uft_baud_gen #(
    .W(DIV_W)
  ) u_baud (
    .core_clk(core_clk),
    .rst(rst),
    .baudDivisor(baudDivisor),
    .divisorLowWrite(baudDivisorLowWrite),
    .baudTick(baudTick)
  ); // [RULE25]

  // External clock pin is synchronised before its edges are used.
  uft_edge_sync u_xck (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(extBitClockPinIn),
    .rise(xckRise),
    .fall(xckFall)
  ); // [RULE15]

  // Clock mode from the synchronous and direction selects; double speed is async only.
  always_comb
  begin
    if (!syncMode)
    begin
      clkMode = doubleSpeedBit ? CLK_ASYNC_2X : CLK_ASYNC;
    end
    else
    begin
      clkMode = extClockIsOutput ? CLK_SYNC_MASTER : CLK_SYNC_SLAVE;
    end
  end

  // Bit strobe, prescaler and master clock output.
  always_comb
  begin
    bitTick = 1'h0;
    preCnt_d = '0;
    xckOut_d = xckOut_q;
    unique case (clkMode)
      CLK_ASYNC:
      begin
        bitTick = baudTick && (preCnt_q == PRE_TERM_NORMAL); // [RULE24] [RULE18]
        preCnt_d = baudTick ? ((preCnt_q == PRE_TERM_NORMAL) ? '0 : preCnt_q + 1'b1) : preCnt_q;
      end
      CLK_ASYNC_2X:
      begin
        bitTick = baudTick && (preCnt_q == PRE_TERM_DOUBLE); // [RULE24] [RULE18]
        preCnt_d = baudTick ? ((preCnt_q >= PRE_TERM_DOUBLE) ? '0 : preCnt_q + 1'b1) : preCnt_q;
      end
      CLK_SYNC_MASTER:
      begin
        // Each tick toggles the pin, so a bit lasts two ticks.
        xckOut_d = baudTick ? ~xckOut_q : xckOut_q; // [RULE24]
        bitTick = baudTick && (xckOut_q == syncClockPolarity); // [RULE26]
      end
      CLK_SYNC_SLAVE:
      begin
        bitTick = syncClockPolarity ? xckFall : xckRise; // [RULE15] [RULE26]
      end
    endcase
  end

  // Next frame from the buffer, laid out under the shared format.
  assign nextFrame = buildFrame(bufData_q, format_q); // [RULE1] [RULE7]

  // Shifter: send the frame one bit per strobe, then reload or go idle.
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    bitsLeft_d = bitsLeft_q;
    loadShifter = 1'h0;
    frameDone = 1'h0;
    if (bitTick && override_q)
    begin
      // The count includes the bit now on the line, so one means the last bit.
      if (state_q == TX_SHIFT && bitsLeft_q > LEN_W'(1))
      begin
        shift_d = {1'h1, shift_q[FRAME_W-1:1]}; // [RULE2] [RULE3]
        bitsLeft_d = bitsLeft_q - 1'b1;
      end
      else if (bufFull_q)
      begin
        // Back to back with no gap after the last stop, or from idle.
        loadShifter = 1'h1; // [RULE17] [RULE4]
        state_d = TX_SHIFT;
        shift_d = nextFrame.bits;
        bitsLeft_d = nextFrame.len;
      end
      else
      begin
        frameDone = (state_q == TX_SHIFT);
        state_d = TX_IDLE; // [RULE4]
        shift_d = '1;
        bitsLeft_d = '0;
      end
    end
  end

  // Transmit buffer: a data write fills it, a shifter load empties it.
  always_comb
  begin
    bufFull_d = bufFull_q;
    bufData_d = bufData_q;
    // The load empties the buffer unless a write lands in the same cycle.
    if (loadShifter)
    begin
      bufFull_d = 1'h0;
    end
    if (charDataRegWrite)
    begin
      // The ninth bit is taken as it stands at the moment of the write.
      bufFull_d = 1'h1; // [RULE16] [RULE20]
      bufData_d = {txNinthBit, charDataRegByte}; // [RULE19]
    end
  end

  // Pin override, line level, flags and shared format.
  always_comb
  begin
    // Disabling waits for the shifter and the buffer to drain.
    override_d = txEnableBit | (override_q & ((state_q == TX_SHIFT) | bufFull_q)); // [RULE14]
    txd_d = (state_d == TX_SHIFT) ? shift_d[0] : 1'h1; // [RULE5] [RULE6]
    txc_d = txc_q;
    if (txCompleteClear)
    begin
      txc_d = 1'h0;
    end
    if (frameDone)
    begin
      txc_d = 1'h1; // [RULE27]
    end
    // The frame error flag follows the receiver's first stop bit only.
    fe_d = fe_q;
    if (rxFirstStopStrobe)
    begin
      fe_d = ~rxFirstStopBit; // [RULE12]
    end
    format_d = frameFormat; // [RULE7] [RULE9] [RULE10] [RULE11]
  end

  // State registers.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      format_q <= '0;
      preCnt_q <= '0;
      xckOut_q <= RST_CLK_OUT;
      bufData_q <= '0;
      bufFull_q <= ~RST_BUF_EMPTY;
      state_q <= TX_IDLE;
      shift_q <= '1;
      bitsLeft_q <= '0;
      txd_q <= RST_LINE;
      override_q <= 1'h0;
      txc_q <= RST_TX_COMPLETE;
      fe_q <= RST_FRAME_ERROR;
    end
    else
    begin
      format_q <= format_d;
      preCnt_q <= preCnt_d;
      xckOut_q <= xckOut_d;
      bufData_q <= bufData_d;
      bufFull_q <= bufFull_d;
      state_q <= state_d;
      shift_q <= shift_d;
      bitsLeft_q <= bitsLeft_d;
      txd_q <= txd_d;
      override_q <= override_d;
      txc_q <= txc_d;
      fe_q <= fe_d;
    end
  end

  // Outputs; the clock pin is driven only in synchronous master mode.
  assign txdOut = txd_q;
  assign txdOverride = override_q;
  assign sharedFormat = format_q;
  assign txBufferEmptyFlag = ~bufFull_q; // [RULE21]
  assign txCompleteFlag = txc_q;
  assign frameErrorFlag = fe_q;
  assign txBusy = (state_q == TX_SHIFT);
  assign extBitClockPinOut = xckOut_q;
  assign extBitClockPinOe_n = ~(clkMode == CLK_SYNC_MASTER);

endmodule

// ==== uft_transmitter_checker.sv ====
// Concurrent checks on the ports of the serial frame transmitter.
`timescale 1ns/100ps
module uft_transmitter_checker
  import uft_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic txEnableBit,
  input uft_format_s frameFormat,
  input wire logic syncMode,
  input wire logic extClockIsOutput,
  input wire logic doubleSpeedBit,
  input wire logic [DIV_W-1:0] baudDivisor,
  input wire logic charDataRegWrite,
  input wire logic rxFirstStopStrobe,
  input wire logic rxFirstStopBit,
  input wire logic extBitClockPinOe_n,
  input wire logic txdOut,
  input wire logic txdOverride,
  input uft_format_s sharedFormat,
  input wire logic txBufferEmptyFlag,
  input wire logic txCompleteFlag,
  input wire logic frameErrorFlag,
  input wire logic txBusy
);
  logic prevTxd_q;
  logic prevTxd_d;
  logic [7:0] runLen_q;
  logic [7:0] runLen_d;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Counts the clocks since the line last changed level.
  always_comb
  begin
    prevTxd_d = txdOut;
    runLen_d = (txdOut != prevTxd_q) ? 8'h00 : runLen_q + 8'h01;
  end

  // Registers the run counter.
  always_ff @(posedge core_clk)
  begin
    prevTxd_q <= rst ? RST_LINE : prevTxd_d;
    runLen_q <= rst ? 8'h00 : runLen_d;
  end

  // A frame starts when the shifter turns busy.
  sequence frame_start_s;
    $rose(txBusy);
  endsequence

  idle_high_a: assert property (!txBusy |-> txdOut)
    else $error("line low while idle");
  start_low_a: assert property (frame_start_s |-> !txdOut)
    else $error("start bit not low");
  load_empties_a: assert property (frame_start_s ##0 !$past(charDataRegWrite) |-> txBufferEmptyFlag)
    else $error("buffer not empty after load");
  write_fills_a: assert property (charDataRegWrite |=> !txBufferEmptyFlag)
    else $error("buffer empty after write");
  bit_period_a: assert property (txBusy && $past(txBusy) && txdOut != prevTxd_q && !syncMode
    && baudDivisor == 12'h000 |-> (doubleSpeedBit ? runLen_q[2:0] == 3'h7 : runLen_q[3:0] == 4'hf))
    else $error("bit period wrong");
  complete_set_a: assert property ($fell(txBusy) |-> ##[0:1] txCompleteFlag)
    else $error("complete flag not set");
  frame_err_a: assert property (rxFirstStopStrobe |=> frameErrorFlag != $past(rxFirstStopBit))
    else $error("frame error flag wrong");
  format_copy_a: assert property (!$past(rst) |-> sharedFormat == $past(frameFormat))
    else $error("shared format differs");
  pin_takeover_a: assert property (txEnableBit |=> txdOverride)
    else $error("pin not taken over");
  clock_drive_a: assert property (extBitClockPinOe_n == !(syncMode && extClockIsOutput))
    else $error("clock pin enable wrong");
endmodule

bind uft_transmitter uft_transmitter_checker chk_u (.core_clk(core_clk), .rst(rst),
  .txEnableBit(txEnableBit), .frameFormat(frameFormat), .syncMode(syncMode),
  .extClockIsOutput(extClockIsOutput), .doubleSpeedBit(doubleSpeedBit),
  .baudDivisor(baudDivisor), .charDataRegWrite(charDataRegWrite),
  .rxFirstStopStrobe(rxFirstStopStrobe), .rxFirstStopBit(rxFirstStopBit),
  .extBitClockPinOe_n(extBitClockPinOe_n), .txdOut(txdOut), .txdOverride(txdOverride),
  .sharedFormat(sharedFormat), .txBufferEmptyFlag(txBufferEmptyFlag),
  .txCompleteFlag(txCompleteFlag), .frameErrorFlag(frameErrorFlag), .txBusy(txBusy));

// ==== uft_transmitter_tb_top.sv ====
// Self-checking testbench of the serial frame transmitter.
`timescale 1ns/100ps
module uft_transmitter_tb_top
  import uft_pkg::*;
;
  logic core_clk = 1'h0, rst = 1'h1, txEnableBit = 1'h0, syncMode = 1'h0;
  logic doubleSpeedBit = 1'h0, baudDivisorLowWrite = 1'h0, charDataRegWrite = 1'h0;
  logic txNinthBit = 1'h0, txCompleteClear = 1'h0, rxFirstStopStrobe = 1'h0;
  logic rxFirstStopBit = 1'h0;
  logic extClockIsOutput = 1'h0, syncClockPolarity = 1'h0;
  logic [7:0] charDataRegByte = 8'h00;
  logic [7:0] bitClks = 8'h10;
  logic [3:0] frameLen = 4'h7;
  logic [DIV_W-1:0] baudDivisor = 12'h000;
  uft_format_s frameFormat = 6'h00;
  uft_format_s sharedFormat;
  logic txdOut, txdOverride, txBufferEmptyFlag, txCompleteFlag, frameErrorFlag, txBusy;
  logic extBitClockPinOe_n, rxDone, xckOut, xckPin;
  logic [12:0] rxBits;
  int nMismatch = 0;
  int cmpCount = 0;

  // Free-running system clock.
  always #10 core_clk = ~core_clk;

  uft_transmitter dut_u (.core_clk(core_clk), .rst(rst), .txEnableBit(txEnableBit),
    .frameFormat(frameFormat), .syncMode(syncMode), .extClockIsOutput(extClockIsOutput),
    .doubleSpeedBit(doubleSpeedBit), .syncClockPolarity(syncClockPolarity),
    .baudDivisor(baudDivisor),
    .baudDivisorLowWrite(baudDivisorLowWrite), .charDataRegWrite(charDataRegWrite),
    .charDataRegByte(charDataRegByte), .txNinthBit(txNinthBit),
    .txCompleteClear(txCompleteClear), .rxFirstStopStrobe(rxFirstStopStrobe),
    .rxFirstStopBit(rxFirstStopBit), .extBitClockPinIn(xckPin), .extBitClockPinOut(xckOut),
    .extBitClockPinOe_n(extBitClockPinOe_n), .txdOut(txdOut), .txdOverride(txdOverride),
    .sharedFormat(sharedFormat), .txBufferEmptyFlag(txBufferEmptyFlag),
    .txCompleteFlag(txCompleteFlag), .frameErrorFlag(frameErrorFlag), .txBusy(txBusy));

  uft_line_monitor mon_u (.core_clk(core_clk), .txdOut(txdOut), .bitClks(bitClks),
    .frameLen(frameLen), .rxBits(rxBits), .rxDone(rxDone),
    .xckOn(syncMode && !extClockIsOutput), .xckPin(xckPin));

  task automatic wrap_up();
    if (nMismatch == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [12:0] expv, input logic [12:0] gotv);
    cmpCount++;
    if (gotv !== expv)
    begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", name, expv, gotv);
    end
  endtask

  // Builds the expected frame, bit 0 first on the line, and its length.
  function automatic logic [12:0] exp_frame(input uft_format_s f, input logic [8:0] d,
    output logic [3:0] len);
    logic [12:0] fr;
    int nb;
    int pos;
    nb = (f.charSizeSel > CSZ_8) ? 8 : int'(f.charSizeSel) + 5;
    if (f.charSizeSel == CSZ_9) nb = 9;
    fr = 13'h1ffe;
    for (int i = 0; i < nb; i++) fr[i + 1] = d[i];
    pos = nb + 1;
    if (f.parityModeSel[PAR_EN_BIT])
    begin
      fr[pos] = ^(d & 9'((1 << nb) - 1)) ^ f.parityModeSel[PAR_ODD_BIT];
      pos++;
    end
    len = 4'(pos + 1 + int'(f.stopBitsSel));
    return fr;
  endfunction

  task automatic wait_busy(input logic lvl);
    for (int n = 0; txBusy !== lvl; n++)
    begin
      if (n > 4000)
      begin
        nMismatch++;
        wrap_up();
      end
      @(negedge core_clk);
    end
  endtask

  task automatic wait_rx(output int w);
    w = 0;
    do
    begin
      @(posedge core_clk);
      w++;
      if (w > 2000)
      begin
        nMismatch++;
        wrap_up();
      end
    end while (rxDone !== 1'h1);
  endtask

  task automatic put_char(input logic [8:0] d);
    logic [3:0] len;
    void'(exp_frame(frameFormat, d, len));
    frameLen = len;
    @(negedge core_clk);
    txNinthBit = d[8];
    @(negedge core_clk);
    charDataRegByte = d[7:0];
    charDataRegWrite = 1'h1;
    @(negedge core_clk);
    charDataRegWrite = 1'h0;
  endtask

  task automatic chk_frame(input logic [8:0] d);
    logic [3:0] len;
    logic [12:0] ex;
    logic [12:0] m;
    ex = exp_frame(frameFormat, d, len);
    m = (13'h0001 << len) - 13'h0001;
    chk("frame", ex & m, rxBits & m);
  endtask

  task automatic frame_check(input logic [8:0] d);
    int w;
    @(negedge core_clk);
    txCompleteClear = 1'h1;
    @(negedge core_clk);
    txCompleteClear = 1'h0;
    chk("shared", 13'(frameFormat), 13'(sharedFormat));
    put_char(d);
    if (txEnableBit !== 1'h1)
    begin
      repeat (40) @(negedge core_clk);
      chk("held", 13'h0001, {11'h000, txdOverride, txdOut});
      txEnableBit = 1'h1;
    end
    wait_rx(w);
    chk_frame(d);
    wait_busy(1'h0);
    repeat (2) @(negedge core_clk);
    chk("complete", 13'h0001, 13'(txCompleteFlag));
  endtask

  // Sends one frame in each of the thirty formats, changed only while idle.
  task automatic scen_formats();
    logic [2:0] sz [5] = '{CSZ_5, CSZ_6, CSZ_7, CSZ_8, CSZ_9};
    logic [1:0] pm [3] = '{PAR_OFF, PAR_EVEN, PAR_ODD};
    for (int s = 0; s < 30; s++)
    begin
      frameFormat = '{sz[s / 6], pm[(s / 2) % 3], 1'(s % 2)};
      frame_check(9'h1a5 ^ 9'(s * 37));
    end
    // Reserved size codes fall back to eight bits, the reserved parity code to none.
    for (int r = 4; r < 7; r++)
    begin
      frameFormat = '{3'(r), 2'h1, 1'h0};
      frame_check(9'h1c3);
    end
  endtask

  // Second character written while the first shifts must follow with no gap.
  task automatic scen_back_to_back();
    int w;
    frameFormat = '{CSZ_8, PAR_OFF, 1'h0};
    put_char(9'h055);
    wait_busy(1'h1);
    put_char(9'h0ca);
    wait_rx(w);
    chk_frame(9'h055);
    wait_rx(w);
    chk("gap", 13'h0a0, 13'(w));
    chk_frame(9'h0ca);
    wait_busy(1'h0);
  endtask

  // Double speed, a larger divisor, synchronous master and slave each set the bit time.
  task automatic scen_rates();
    logic [23:0] cfg [6] = '{{4'h1, 12'h000, 8'h08}, {4'h0, 12'h002, 8'h30},
      {4'hc, 12'h003, 8'h08}, {4'he, 12'h003, 8'h08}, {4'h8, 12'h000, 8'h08},
      {4'ha, 12'h000, 8'h08}};
    logic xo;
    for (int k = 0; k < 6; k++)
    begin
      {syncMode, extClockIsOutput, syncClockPolarity, doubleSpeedBit, baudDivisor,
        bitClks} = cfg[k];
      baudDivisorLowWrite = 1'h1;
      @(negedge core_clk);
      baudDivisorLowWrite = 1'h0;
      chk("clk_oe", 13'(!(syncMode && extClockIsOutput)), 13'(extBitClockPinOe_n));
      xo = xckOut;
      repeat (4) @(negedge core_clk);
      chk("clk_out", 13'((syncMode && extClockIsOutput) ? !xo : xo), 13'(xckOut));
      frame_check(9'h0a5);
    end
  endtask

  task automatic scen_frame_error();
    for (int v = 0; v < 2; v++)
    begin
      rxFirstStopStrobe = 1'h1;
      rxFirstStopBit = 1'(v);
      @(negedge core_clk);
      rxFirstStopStrobe = 1'h0;
      repeat (2) @(negedge core_clk);
      chk("frame_error", 13'(1 - v), 13'(frameErrorFlag));
    end
  endtask

  // Resets, then runs each scenario in turn.
  initial
  begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'h0;
    @(negedge core_clk);
    chk("reset", 13'h0018, {8'h00, txdOut, txBufferEmptyFlag, txCompleteFlag, txBusy,
      txdOverride});
    scen_formats();
    scen_back_to_back();
    scen_rates();
    scen_frame_error();
    wrap_up();
  end
endmodule
